// *** hdl/host_port_device.sv ***
// Device end of the windowed host bus port: register window, service
// acknowledge context, post-service stretching and per-channel bit timers.
// Assumes pin inputs synchronous to clk_sys_i.
//
// Operation
// - Channel pointer selects per-channel register window
// - Eight-bit data bus, seven-bit address bus
// - Internal clock is system clock halved
// - Strobes sampled on internal falling edges
// - Late strobes start cycle two clocks later
// - Read needs both strobes, read/write high
// - Read drives data and asserts acknowledge on the same clock
// - Host ends cycle by removing strobes
// - Host holds read/write low writing
// - Write acknowledged after data taken
// - Service acknowledge replaces chip select
// - Service acknowledge returns type's vector
// - End-of-service starts about 1 us housekeeping
// - Accesses stretched during housekeeping
// - Non-monitoring host waits after end-of-service
// - Some locations read live hardware
// - Bit engines signal after every bit
// - Parallel channel 0 times printer handshake
// - Vector: local upper five, type code lower
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module host_port_device
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    host_port_if.device     bus,
    input  wire logic [2:0] svc_req_i,
    input  wire logic [5:0] svc_req_chan_i,
    input  wire logic [2:0] rx_vec_code_i,
    input  wire logic [3:0] modem_in_i,
    input  wire logic       print_req_i,
    input  wire logic       printer_ack_in_n_i,
    output logic            in_service_o,
    output logic [3:0]      bit_done_o,
    output logic            printer_strobe_out_n_o,
    output logic            printer_acked_o
);

    ////////////////////////////////////////////////////////////////////////
    // Internal clock phase and sampled pins.

    logic                         phase;
    logic                         s_cs;
    logic                         s_ds;
    logic                         s_rw;
    logic [2:0]                   s_ack;
    logic [6:0]                   s_addr;
    logic [7:0]                   s_wdata;
    host_port_pkg::dev_state_type state;
    host_port_pkg::cycle_kind_type kind;
    logic [1:0]                   channel_pointer_reg;
    logic [1:0]                   saved_pointer;
    logic [7:0]                   local_vector_reg;
    logic [7:0]                   hk_cnt;
    logic [7:0]                   mem [0:255];

    // The falling edge of the halved clock is every second system edge.
    wire sample_en = phase;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            phase <= 1'b0;
        else
            phase <= ~phase;
    end

    // A strobe that misses this edge is seen on the next, two clocks on.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_cs    <= 1'b0;
            s_ds    <= 1'b0;
            s_rw    <= 1'b1;
            s_ack   <= 3'h0;
            s_addr  <= 7'h00;
            s_wdata <= 8'h00;
        end
        else if (sample_en)
        begin
            s_cs    <= ~bus.cs_n;
            s_ds    <= ~bus.data_strobe_n;
            s_rw    <= bus.rw;
            s_ack   <= ~bus.service_ack_select_n;
            s_addr  <= bus.addr;
            s_wdata <= bus.data_bus;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoding.

    function automatic logic [7:0] window_index(input logic [6:0] a, input logic [1:0] ch);
        window_index = (a[6:5] == `CHAN_AREA) ? {1'b1, ch, a[4:0]} : {1'b0, a};
    endfunction

    wire       start     = s_ds && (s_cs || (s_ack != 3'h0));
    wire       busy      = (hk_cnt != 8'h00);
    wire       is_ack    = (s_ack != 3'h0);
    wire [1:0] ack_type  = s_ack[0] ? 2'd0 : (s_ack[1] ? 2'd1 : 2'd2);
    wire [1:0] req_chan  = svc_req_chan_i[2 * ack_type +: 2];
    wire [2:0] type_code = s_ack[0] ? rx_vec_code_i :
                           (s_ack[1] ? `VEC_TX_CODE : `VEC_MODEM_CODE);
    wire [7:0] vector    = {local_vector_reg[7:3], type_code};
    wire [7:0] cur_index = window_index(s_addr, channel_pointer_reg);
    wire [7:0] reg_value =
        (s_addr == `CHAN_PTR_ADDR)  ? {6'h00, channel_pointer_reg} :
        (s_addr == `LOCAL_VEC_ADDR) ? local_vector_reg :
        (s_addr == `SVC_REQ_ADDR)   ? {5'h00, svc_req_i} :
        (s_addr == `MODEM_IN_ADDR)  ? {7'h00, modem_in_i[channel_pointer_reg]} :
        mem[cur_index];
    wire       do_access = sample_en && (state == host_port_pkg::DEV_WAIT) && !busy;
    wire       do_write  = do_access && !is_ack && s_cs && !s_rw;
    wire       released  = sample_en && !s_ds && !s_cs && !is_ack;

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer.

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state              <= host_port_pkg::DEV_IDLE;
            kind               <= host_port_pkg::KIND_READ;
            bus.transfer_ack_n <= 1'b1;
            bus.dev_data_oe_n  <= 1'b1;
            bus.dev_data       <= 8'h00;
        end
        else
        begin
            unique case (state)
                host_port_pkg::DEV_IDLE:
                    if (sample_en && start)
                    begin
                        state <= host_port_pkg::DEV_WAIT;
                        kind  <= is_ack ? host_port_pkg::KIND_ACK :
                                 (s_rw ? host_port_pkg::KIND_READ : host_port_pkg::KIND_WRITE);
                    end
                host_port_pkg::DEV_WAIT:
                    if (do_access)
                    begin
                        state              <= host_port_pkg::DEV_HOLD;
                        bus.transfer_ack_n <= 1'b0;
                        bus.dev_data_oe_n  <= (kind == host_port_pkg::KIND_WRITE);
                        bus.dev_data       <= is_ack ? vector : reg_value;
                    end
                host_port_pkg::DEV_HOLD:
                    if (released)
                    begin
                        state              <= host_port_pkg::DEV_IDLE;
                        bus.transfer_ack_n <= 1'b1;
                        bus.dev_data_oe_n  <= 1'b1;
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel window, service context and housekeeping.

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            channel_pointer_reg <= `CHAN_PTR_RESET;
            saved_pointer       <= `CHAN_PTR_RESET;
            local_vector_reg    <= `LOCAL_VEC_RESET;
            in_service_o        <= 1'b0;
            hk_cnt              <= 8'h00;
        end
        else
        begin
            if (busy)
                hk_cnt <= hk_cnt - 8'h01;
            if (do_access && is_ack)
            begin
                saved_pointer       <= channel_pointer_reg;
                channel_pointer_reg <= req_chan;
                in_service_o        <= 1'b1;
            end
            else if (do_write && (s_addr == `CHAN_PTR_ADDR))
                channel_pointer_reg <= s_wdata[1:0];
            else if (do_write && (s_addr == `LOCAL_VEC_ADDR))
                local_vector_reg <= s_wdata;
            else if (do_write && (s_addr == `END_SERVICE_ADDR))
            begin
                channel_pointer_reg <= saved_pointer;
                in_service_o        <= 1'b0;
                hk_cnt              <= 8'(`HOUSEKEEP_CYCLES);
            end
        end
    end

    // Register RAM has no reset; software owns its contents.
    always_ff @(posedge clk_sys_i)
    begin
        if (do_write)
            mem[cur_index] <= s_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit engines: a divisor of zero stops a channel's bit timer.

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_engine
            logic [7:0] bit_cnt;
            wire  [7:0] divisor = mem[{1'b1, 2'(ch), `BIT_DIV_OFS}];
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    bit_cnt        <= 8'h00;
                    bit_done_o[ch] <= 1'b0;
                end
                else
                begin
                    bit_done_o[ch] <= 1'b0;
                    if (sample_en && (divisor != 8'h00))
                    begin
                        bit_cnt        <= (bit_cnt >= divisor - 8'h01) ? 8'h00 : bit_cnt + 8'h01;
                        bit_done_o[ch] <= (bit_cnt >= divisor - 8'h01);
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Parallel handshake on channel 0: bit 0 enables, bits 7:1 give the width.

    logic [6:0] strobe_cnt;
    logic       print_pend;
    wire  [7:0] par_cfg = mem[{1'b1, 2'h0, `PAR_CFG_OFS}];
    wire        print_go = par_cfg[0] && printer_strobe_out_n_o && (print_req_i || print_pend);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            strobe_cnt             <= 7'h00;
            printer_strobe_out_n_o <= 1'b1;
            printer_acked_o        <= 1'b0;
            print_pend             <= 1'b0;
        end
        else
        begin
            printer_acked_o <= par_cfg[0] && !printer_ack_in_n_i;
            print_pend      <= print_go && !sample_en;
            if (sample_en && print_go)
            begin
                strobe_cnt             <= par_cfg[7:1];
                printer_strobe_out_n_o <= (par_cfg[7:1] == 7'h00);
            end
            else if (sample_en && !printer_strobe_out_n_o)
            begin
                strobe_cnt             <= strobe_cnt - 7'h01;
                printer_strobe_out_n_o <= (strobe_cnt <= 7'h01);
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/host_port_params.svh ***
// Constants shared by both ends of the windowed host bus port.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define CLK_PERIOD_PS     5000
`define HOUSEKEEP_NS      1000
`define HOUSEKEEP_CYCLES  ((`HOUSEKEEP_NS * 1000) / `CLK_PERIOD_PS)

`define CHAN_PTR_ADDR     7'h40
`define LOCAL_VEC_ADDR    7'h41
`define END_SERVICE_ADDR  7'h42
`define SVC_REQ_ADDR      7'h43
`define MODEM_IN_ADDR     7'h44
`define CHAN_AREA         2'h3
`define BIT_DIV_OFS       5'h10
`define PAR_CFG_OFS       5'h11

`define VEC_TX_CODE       3'h2
`define VEC_MODEM_CODE    3'h1
`define CHAN_PTR_RESET    2'h0
`define LOCAL_VEC_RESET   8'h00

`endif

// *** hdl/host_port_pkg.sv ***
// Types shared by both ends of the windowed host bus port.
// Assumes nothing of its surroundings.
package host_port_pkg;
    typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_ACK} cycle_kind_type;
    typedef enum {DEV_IDLE, DEV_WAIT, DEV_HOLD} dev_state_type;
    typedef enum {HOST_IDLE, HOST_WAIT, HOST_GAP} host_state_type;
endpackage

// *** hdl/host_port_if.sv ***
// Pins between the host and the device, with the shared data bus resolved.
// Assumes the host drives data only on writes and the device only on reads and service acknowledges.
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    logic       cs_n;
    logic       data_strobe_n;
    logic       rw;
    logic [2:0] service_ack_select_n;
    logic [6:0] addr;
    logic [7:0] host_data;
    logic       host_data_oe_n;
    logic [7:0] dev_data;
    logic       dev_data_oe_n;
    logic       transfer_ack_n;
    wire  [7:0] data_bus = !dev_data_oe_n ? dev_data : host_data;

    modport device (input cs_n, data_strobe_n, rw, service_ack_select_n, addr, data_bus,
                    output dev_data, dev_data_oe_n, transfer_ack_n);
    modport host   (input transfer_ack_n, data_bus,
                    output cs_n, data_strobe_n, rw, service_ack_select_n, addr,
                    host_data, host_data_oe_n);
endinterface
`default_nettype wire

// *** hdl/host_port_host.sv ***
// Host end of the windowed host bus port: runs one read, write or
// service acknowledge cycle per request and waits on the acknowledge.
// Assumes the device end sits across host_port_if.
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module host_port_host
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    host_port_if.host       bus,
    input  wire logic       req_valid_i,
    input  wire logic [1:0] req_kind_i,
    input  wire logic [1:0] req_ack_type_i,
    input  wire logic [6:0] req_addr_i,
    input  wire logic [7:0] req_wdata_i,
    output logic            req_ready_o,
    output logic            done_o,
    output logic [7:0]      rdata_o
);

    host_port_pkg::host_state_type state;
    logic [7:0]                    guard_cnt;
    logic                          was_eos;

    wire is_write = (req_kind_i == host_port_pkg::KIND_WRITE);
    wire is_ack   = (req_kind_i == host_port_pkg::KIND_ACK);
    wire take     = (state == host_port_pkg::HOST_IDLE) && req_valid_i && (guard_cnt == 8'h00);
    wire [2:0] sel_n = ~(3'h1 << req_ack_type_i);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state                    <= host_port_pkg::HOST_IDLE;
            bus.cs_n                 <= 1'b1;
            bus.data_strobe_n        <= 1'b1;
            bus.rw                   <= 1'b1;
            bus.service_ack_select_n <= 3'h7;
            bus.addr                 <= 7'h00;
            bus.host_data            <= 8'h00;
            bus.host_data_oe_n       <= 1'b1;
            req_ready_o              <= 1'b0;
            done_o                   <= 1'b0;
            rdata_o                  <= 8'h00;
            guard_cnt                <= 8'h00;
            was_eos                  <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (guard_cnt != 8'h00)
                guard_cnt <= guard_cnt - 8'h01;
            req_ready_o <= (state == host_port_pkg::HOST_IDLE) && !take && (guard_cnt <= 8'h01);
            unique case (state)
                host_port_pkg::HOST_IDLE:
                    if (take)
                    begin
                        state                    <= host_port_pkg::HOST_WAIT;
                        req_ready_o              <= 1'b0;
                        bus.addr                 <= req_addr_i;
                        bus.rw                   <= !is_write;
                        bus.host_data            <= req_wdata_i;
                        bus.host_data_oe_n       <= !is_write;
                        bus.cs_n                 <= is_ack;
                        bus.service_ack_select_n <= is_ack ? sel_n : 3'h7;
                        bus.data_strobe_n        <= 1'b0;
                        was_eos                  <= is_write && (req_addr_i == `END_SERVICE_ADDR);
                    end
                host_port_pkg::HOST_WAIT:
                    if (!bus.transfer_ack_n)
                    begin
                        state                    <= host_port_pkg::HOST_GAP;
                        rdata_o                  <= bus.data_bus;
                        done_o                   <= 1'b1;
                        bus.cs_n                 <= 1'b1;
                        bus.data_strobe_n        <= 1'b1;
                        bus.service_ack_select_n <= 3'h7;
                        bus.host_data_oe_n       <= 1'b1;
                        if (was_eos)
                            guard_cnt <= 8'(`HOUSEKEEP_CYCLES);
                    end
                host_port_pkg::HOST_GAP:
                    if (bus.transfer_ack_n)
                        state <= host_port_pkg::HOST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** verification/host_port_asserts.sv ***
// Checker for the pins between the host end and the device end.
// Assumes it is instantiated beside the interface with its signals as inputs.
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module host_port_asserts
(
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       cs_n,
    input wire logic       data_strobe_n,
    input wire logic       rw,
    input wire logic [2:0] service_ack_select_n,
    input wire logic [7:0] data_bus,
    input wire logic       dev_data_oe_n,
    input wire logic       transfer_ack_n
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge may only fall on the internal clock's parity.
    logic tog;
    logic fall_par;
    logic seen_fall;
    wire  strobes_off = data_strobe_n && cs_n && (&service_ack_select_n);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tog       <= 1'b0;
            fall_par  <= 1'b0;
            seen_fall <= 1'b0;
        end
        else
        begin
            tog <= ~tog;
            if (transfer_ack_n === 1'b0 && !seen_fall)
                seen_fall <= 1'b1;
            if ($fell(transfer_ack_n))
                fall_par <= tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_ack_after_strobe: assert property ($fell(transfer_ack_n) |-> $past(!data_strobe_n, 2) &&
        ($past(!cs_n, 2) || $past(service_ack_select_n, 2) != 3'h7)) else $error("ack without strobes");
    a_ack_prompt: assert property ($fell(data_strobe_n) |-> transfer_ack_n ##[5:6] !transfer_ack_n)
        else $error("ack late or early");
    a_ack_holds: assert property (!transfer_ack_n && !data_strobe_n |=> !transfer_ack_n)
        else $error("ack dropped while strobed");
    a_ack_release: assert property (strobes_off [*4] |-> transfer_ack_n && dev_data_oe_n)
        else $error("ack or data held after strobes left");
    a_oe_only_ack: assert property (!dev_data_oe_n |-> !transfer_ack_n)
        else $error("data bus driven outside a cycle");
    a_read_data_out: assert property ($fell(transfer_ack_n) && rw |-> !dev_data_oe_n)
        else $error("read acked without data");
    a_write_no_drive: assert property (!transfer_ack_n && !rw |-> dev_data_oe_n)
        else $error("device drives during write");
    a_tx_vector: assert property ($fell(transfer_ack_n) && service_ack_select_n == 3'h5
        |-> data_bus[2:0] == `VEC_TX_CODE) else $error("bad transmit vector code");
    a_modem_vector: assert property ($fell(transfer_ack_n) && service_ack_select_n == 3'h3
        |-> data_bus[2:0] == `VEC_MODEM_CODE) else $error("bad modem vector code");
    a_ack_phase: assert property ($fell(transfer_ack_n) && seen_fall |-> tog == fall_par)
        else $error("ack off the internal clock phase");

    c_write: cover property ($fell(transfer_ack_n) && !rw);
    c_read: cover property ($fell(transfer_ack_n) && rw && !cs_n);
    c_service: cover property ($fell(transfer_ack_n) && service_ack_select_n != 3'h7);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Testbench: host end and device end joined, plus a lone device driven at its pins.
// Assumes the design files and the shared header are compiled first.
`timescale 1ns/1ps
`include "host_port_params.svh"
`default_nettype none
module testbench;
    logic       clk_sys_i;
    logic       rst_i;
    logic       req_valid_i;
    logic [1:0] req_kind_i;
    logic [1:0] req_ack_type_i;
    logic [6:0] req_addr_i;
    logic [7:0] req_wdata_i;
    logic       req_ready_o;
    logic       done_o;
    logic [7:0] rdata_o;
    logic [2:0] svc_req_i;
    logic [5:0] svc_req_chan_i;
    logic [2:0] rx_vec_code_i;
    logic [3:0] modem_in_i;
    logic       print_req_i;
    logic       printer_ack_in_n_i;
    logic       in_service_o;
    logic [3:0] bit_done_o;
    logic       printer_strobe_out_n_o;
    logic       printer_acked_o;
    logic [7:0] d;
    logic [2:0] code;
    int         n_fail;
    int         n_checks;
    int         lat;
    int         lat_a;
    int         n;
    int         i;

    host_port_if bus ();
    host_port_if bus2 ();
    host_port_host host_port_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus),
        .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_ack_type_i(req_ack_type_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .rdata_o(rdata_o));
    host_port_device host_port_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus),
        .svc_req_i(svc_req_i), .svc_req_chan_i(svc_req_chan_i), .rx_vec_code_i(rx_vec_code_i),
        .modem_in_i(modem_in_i), .print_req_i(print_req_i),
        .printer_ack_in_n_i(printer_ack_in_n_i), .in_service_o(in_service_o),
        .bit_done_o(bit_done_o), .printer_strobe_out_n_o(printer_strobe_out_n_o),
        .printer_acked_o(printer_acked_o));
    // The lone device faces a pin driver that ignores the post-service wait on purpose.
    host_port_device host_port_device_lone_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus2),
        .svc_req_i(svc_req_i), .svc_req_chan_i(svc_req_chan_i), .rx_vec_code_i(rx_vec_code_i),
        .modem_in_i(modem_in_i), .print_req_i(1'b0), .printer_ack_in_n_i(printer_ack_in_n_i),
        .in_service_o(), .bit_done_o(), .printer_strobe_out_n_o(), .printer_acked_o());
    host_port_asserts host_port_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .cs_n(bus.cs_n), .data_strobe_n(bus.data_strobe_n), .rw(bus.rw),
        .service_ack_select_n(bus.service_ack_select_n), .data_bus(bus.data_bus),
        .dev_data_oe_n(bus.dev_data_oe_n), .transfer_ack_n(bus.transfer_ack_n));

    ////////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task host_op(input logic [1:0] kind, input logic [1:0] atype, input logic [6:0] a,
                 input logic [7:0] v);
        for (i = 0; i < 1000 && req_ready_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
        req_kind_i = kind;
        req_ack_type_i = atype;
        req_addr_i = a;
        req_wdata_i = v;
        req_valid_i = 1'b1;
        @(posedge clk_sys_i) #1;
        req_valid_i = 1'b0;
        for (i = 0; i < 1000 && done_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
        check("host done", 8'h01, {7'h00, done_o});
        d = rdata_o;
    endtask

    task wr(input logic [6:0] a, input logic [7:0] v);
        host_op(host_port_pkg::KIND_WRITE, 2'h0, a, v);
    endtask

    task rd(input logic [6:0] a);
        host_op(host_port_pkg::KIND_READ, 2'h0, a, 8'h00);
    endtask

    // Released data lines show the inverse of the last byte.
    task pin(input logic [2:0] sel, input logic r, input logic [6:0] a, input logic [7:0] v);
        bus2.cs_n = (sel != 3'h7);
        bus2.service_ack_select_n = sel;
        bus2.rw = r;
        bus2.addr = a;
        bus2.host_data = v;
        bus2.host_data_oe_n = r;
        bus2.data_strobe_n = 1'b0;
        for (lat = 0; lat < 400 && bus2.transfer_ack_n !== 1'b0; lat++) @(posedge clk_sys_i) #1;
        d = bus2.data_bus;
        bus2.cs_n = 1'b1;
        bus2.data_strobe_n = 1'b1;
        bus2.service_ack_select_n = 3'h7;
        bus2.host_data_oe_n = 1'b1;
        bus2.host_data = ~v;
        for (i = 0; i < 10 && bus2.transfer_ack_n !== 1'b1; i++) @(posedge clk_sys_i) #1;
        @(posedge clk_sys_i) #1;
        check("pin cycle ends", 8'h01, {7'h00, lat < 400 && i < 10});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_window();
        for (int c = 0; c < 4; c++)
        begin
            wr(`CHAN_PTR_ADDR, 8'(c));
            wr(7'h60, 8'ha0 + 8'(c));
        end
        wr(7'h10, 8'h5a);
        for (int c = 3; c >= 0; c--)
        begin
            wr(`CHAN_PTR_ADDR, 8'(c));
            rd(7'h60);
            check("window", 8'ha0 + 8'(c), d);
            rd(`CHAN_PTR_ADDR);
            check("pointer", 8'(c), {6'h00, d[1:0]});
        end
        rd(7'h10);
        check("global ram", 8'h5a, d);
    endtask

    task t_live();
        svc_req_i = 3'h5;
        wr(`SVC_REQ_ADDR, 8'hff);
        rd(`SVC_REQ_ADDR);
        check("live request", 8'h05, {5'h00, d[2:0]});
        modem_in_i = 4'h4;
        for (int c = 1; c < 3; c++)
        begin
            wr(`CHAN_PTR_ADDR, 8'(c));
            rd(`MODEM_IN_ADDR);
            check("live modem", {7'h00, modem_in_i[c]}, {7'h00, d[0]});
        end
    endtask

    task t_service();
        wr(`LOCAL_VEC_ADDR, 8'hb8);
        wr(`CHAN_PTR_ADDR, 8'h03);
        svc_req_i = 3'h7;
        svc_req_chan_i = 6'h09;
        rx_vec_code_i = 3'h3;
        for (int t = 0; t < 3; t++)
        begin
            code = (t == 0) ? 3'h3 : (t == 1) ? `VEC_TX_CODE : `VEC_MODEM_CODE;
            host_op(host_port_pkg::KIND_ACK, 2'(t), 7'h00, 8'h00);
            check("vector", {5'h17, code}, d);
            check("in service", 8'h01, {7'h00, in_service_o});
            rd(7'h60);
            check("ack window", 8'ha0 + {6'h00, svc_req_chan_i[2*t +: 2]}, d);
            wr(`END_SERVICE_ADDR, 8'h00);
            check("service over", 8'h00, {7'h00, in_service_o});
            rd(`CHAN_PTR_ADDR);
            check("pointer back", 8'h03, {6'h00, d[1:0]});
        end
    endtask

    task t_engines();
        wr(`CHAN_PTR_ADDR, 8'h01);
        wr({`CHAN_AREA, `BIT_DIV_OFS}, 8'h04);
        n = 0;
        repeat (160) @(posedge clk_sys_i) #1 n += bit_done_o[1];
        check("bit pulses", 8'h14, 8'(n));
        wr({`CHAN_AREA, `BIT_DIV_OFS}, 8'h00);
        wr(`CHAN_PTR_ADDR, 8'h00);
        wr({`CHAN_AREA, `PAR_CFG_OFS}, 8'h0b);
        print_req_i = 1'b1;
        @(posedge clk_sys_i) #1;
        print_req_i = 1'b0;
        for (i = 0; i < 10 && printer_strobe_out_n_o !== 1'b0; i++) @(posedge clk_sys_i) #1;
        for (n = 0; n < 100 && printer_strobe_out_n_o === 1'b0; n++) @(posedge clk_sys_i) #1;
        check("strobe width", 8'h0a, 8'(n));
        printer_ack_in_n_i = 1'b0;
        repeat (4) @(posedge clk_sys_i) #1;
        check("printer acked", 8'h01, {7'h00, printer_acked_o});
        printer_ack_in_n_i = 1'b1;
        repeat (4) @(posedge clk_sys_i) #1;
        check("printer idle", 8'h00, {7'h00, printer_acked_o});
        wr({`CHAN_AREA, `PAR_CFG_OFS}, 8'h00);
    endtask

    task t_stretch();
        pin(3'h6, 1'b1, 7'h00, 8'h00);
        pin(3'h7, 1'b0, `END_SERVICE_ADDR, 8'h00);
        pin(3'h7, 1'b1, `CHAN_PTR_ADDR, 8'h00);
        check("stretch", 8'h01, {7'h00, lat > `HOUSEKEEP_CYCLES - 12 &&
            lat <= `HOUSEKEEP_CYCLES + 4});
        check("after stretch", 8'h00, {6'h00, d[1:0]});
        pin(3'h7, 1'b1, `CHAN_PTR_ADDR, 8'h00);
        lat_a = lat;
        @(posedge clk_sys_i) #1;
        pin(3'h7, 1'b1, `CHAN_PTR_ADDR, 8'h00);
        check("phase", 8'h01, {7'h00, lat_a + lat == 11});
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // A few thousand cycles suffice; forty thousand means a hang.
    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial
    begin
        {n_fail, n_checks, lat, lat_a, n, i} = '0;
        {rst_i, req_valid_i, req_kind_i, req_ack_type_i, req_addr_i, req_wdata_i} = 21'h100000;
        {svc_req_i, svc_req_chan_i, rx_vec_code_i, modem_in_i, print_req_i} = '0;
        printer_ack_in_n_i = 1'b1;
        {bus2.cs_n, bus2.data_strobe_n, bus2.rw, bus2.service_ack_select_n} = 6'h3f;
        {bus2.addr, bus2.host_data, bus2.host_data_oe_n} = 16'h0001;
        repeat (12) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        t_window();
        t_live();
        t_service();
        t_engines();
        t_stretch();
        complete_run();
    end
endmodule
`default_nettype wire
